// ### rtl/csg_defs.svh
`ifndef CSG_DEFS_SVH
`define CSG_DEFS_SVH

// ****************************************
// Address map
// ****************************************
// Unlock key words, memory-bus frame zero
`define CSG_KEY_BASE 22'h000AE0
// Password words in flash
`define CSG_PW_BASE 22'h33FFF8
// Flash array
`define CSG_FLASH_LO 22'h300000
`define CSG_FLASH_HI 22'h33FFFF
// One-time-programmable area
`define CSG_OTP_LO 22'h380400
`define CSG_OTP_HI 22'h3807FF
// Local single-access RAM blocks zero to three
`define CSG_LRAM_LO 22'h008000
`define CSG_LRAM_HI 22'h00BFFF

// ****************************************
// Field layout and timing
// ****************************************
// Key and password words of 16 bits
`define CSG_NUM_WORDS 8
// Fixed wait states of a password read
`define CSG_PW_WAIT 5'h10
// Reset value of key words
`define CSG_KEY_RST 16'h0000

`endif

// ### rtl/csg_pkg.sv
package csg_pkg;

   // Origin of a memory access
   typedef enum logic [1:0] {
      CSG_SRC_CPU,
      CSG_SRC_JTAG,
      CSG_SRC_EXT,
      CSG_SRC_BOOT
   } csg_src_e;

   // Password read sequencer states
   typedef enum logic {
      CSG_RD_IDLE,
      CSG_RD_WAIT
   } csg_rd_e;

   // Bus front end states
   typedef enum logic [1:0] {
      CSG_BUS_IDLE,
      CSG_BUS_PW,
      CSG_BUS_ACK
   } csg_bus_e;

endpackage

// ### rtl/csg_pw_if.sv
`timescale 1ns/1ps

// Password, key and compare results shared between the gate's parts
interface csg_pw_if;
   // Password as read from flash
   logic [127:0] pw;
   // One bit per password word that has been read
   logic [7:0] seen;
   // Key as written by software
   logic [127:0] key;
   // Compare results
   logic full_match;
   logic low_match;

   modport reader (output pw, output seen);
   modport cmp (input pw, input key, output full_match, output low_match);
   modport gate (input pw, input seen, input full_match, input low_match, output key);
endinterface // csg_pw_if

// ### rtl/csg_pw_reader.sv
`timescale 1ns/1ps
`include "csg_defs.svh"

module csg_pw_reader
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Read request
   input wire logic rd_start_i,
   input wire logic [2:0] rd_idx_i,
   // Flash data
   input wire logic [15:0] fl_rdata_i,
   // Read result
   output logic rd_done_o,
   output logic [15:0] rd_data_o,
   // Password store
   csg_pw_if.reader pw_bus
);

   // ****************************************
   // Sequencer
   // ****************************************
   csg_pkg::csg_rd_e state_ff; // Sequencer state
   logic [4:0] cnt_ff; // Wait state counter
   logic [2:0] idx_ff; // Word being read
   logic [15:0] word_ff [8]; // Captured words
   logic last_wait; // Final wait state

   assign last_wait = (state_ff == csg_pkg::CSG_RD_WAIT) && (cnt_ff == `CSG_PW_WAIT - 5'h01);

   // State and wait counter
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         state_ff <= csg_pkg::CSG_RD_IDLE;
         cnt_ff <= 5'h00;
         idx_ff <= 3'h0;
      end
      else
      begin
         case (state_ff)
            csg_pkg::CSG_RD_IDLE:
            begin
               // Start a fixed-length read
               if (rd_start_i)
               begin
                  state_ff <= csg_pkg::CSG_RD_WAIT;
                  cnt_ff <= 5'h00;
                  idx_ff <= rd_idx_i;
               end
            end
            default:
            begin
               if (last_wait)
                  state_ff <= csg_pkg::CSG_RD_IDLE;
               else
                  cnt_ff <= cnt_ff + 5'h01;
            end
         endcase
      end
   end

   // Done pulse and read data
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         rd_done_o <= 1'b0;
         rd_data_o <= 16'h0000;
      end
      else
      begin
         rd_done_o <= last_wait;
         if (last_wait)
            rd_data_o <= fl_rdata_i;
      end
   end

   // ****************************************
   // Per-word capture
   // ****************************************
   // record each dummy read
   for (genvar g = 0; g < `CSG_NUM_WORDS; g++)
   begin : g_word
      always_ff @(posedge clk_i)
      begin
         if (srst_i)
         begin
            word_ff[g] <= 16'hFFFF;
            pw_bus.seen[g] <= 1'b0;
         end
         else if (last_wait && (idx_ff == 3'(g)))
         begin
            word_ff[g] <= fl_rdata_i;
            pw_bus.seen[g] <= 1'b1;
         end
      end
      assign pw_bus.pw[16*g +: 16] = word_ff[g];
   end

   // ****************************************
   // Checks
   // ****************************************
   chk_wait_len: assert property (@(posedge clk_i) disable iff (srst_i)
      (state_ff == csg_pkg::CSG_RD_IDLE) && rd_start_i |-> ##17 rd_done_o)
      else $error("password read did not finish after 16 waits");

endmodule // csg_pw_reader

// ### rtl/csg_key_cmp.sv
`timescale 1ns/1ps

module csg_key_cmp
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Key and password
   csg_pw_if.cmp pw_bus
);

   // ****************************************
   // Compare
   // ****************************************
   logic pw_zero; // Forbidden password
   logic low_blank; // Lower half unprogrammed
   logic full_ff;
   logic low_ff;

   assign pw_zero = (pw_bus.pw == 128'h0);
   assign low_blank = (pw_bus.pw[63:0] == {64{1'b1}});

   // Registered match flags
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         full_ff <= 1'b0;
         low_ff <= 1'b0;
      end
      else
      begin
         full_ff <= !pw_zero && (pw_bus.key == pw_bus.pw);
         low_ff <= !pw_zero && (low_blank || (pw_bus.key[63:0] == pw_bus.pw[63:0]));
      end
   end

   assign pw_bus.full_match = full_ff;
   assign pw_bus.low_match = low_ff;

   // ****************************************
   // Checks
   // ****************************************
   chk_zero_pw: assert property (@(posedge clk_i) disable iff (srst_i)
      $past(pw_bus.pw == 128'h0) |-> !full_ff && !low_ff)
      else $error("all-zero password produced a match");

   chk_blank_low: assert property (@(posedge clk_i) disable iff (srst_i)
      $past(pw_bus.pw[63:0] == {64{1'b1}}) && !$past(srst_i) |-> low_ff)
      else $error("blank lower half did not match");

endmodule // csg_key_cmp

// ### rtl/csg_gate.sv
`timescale 1ns/1ps
`include "csg_defs.svh"

// Notes on behaviour
// - Guard covers flash, OTP, local RAM zero-three
// - Locked: refuse JTAG, external, bootloader reads
// - Unlock needs full 128-bit key match
// - All password words must be read first
// - Secure access with emulator cuts link unless emulation allowed
// - Lower-half match allows emulation only
// - Blank lower password half always matches
// - Password reads use sixteen fixed waits
// - All-zero password never unlocks
// - Emulator may hold device in reset
// - Key registers sit on memory bus
module csg_gate
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // CPU memory bus, key and password words
   input wire logic cpu_req_i,
   input wire logic cpu_we_i,
   input wire logic [21:0] cpu_addr_i,
   input wire logic [15:0] cpu_wdata_i,
   output logic cpu_ack_o,
   output logic [15:0] cpu_rdata_o,
   // Flash read port
   output logic [21:0] fl_addr_o,
   input wire logic [15:0] fl_rdata_i,
   // Access check
   input wire logic acc_valid_i,
   input wire logic [21:0] acc_addr_i,
   input wire csg_pkg::csg_src_e acc_src_i,
   output logic acc_secure_o,
   output logic acc_grant_o,
   // Emulator pins
   input wire logic emu_present_i,
   input wire logic emu_hold_req_i,
   output logic emu_link_en_o,
   output logic cpu_hold_o,
   // Status
   output logic locked_o,
   output logic emu_unlocked_o
);

   // ****************************************
   // Shared password and key
   // ****************************************
   csg_pw_if pw_bus ();

   logic [15:0] key_ff [8]; // Unlock key words
   logic rd_start; // Start a password read
   logic rd_done; // Password read finished
   logic [15:0] rd_data; // Password read data

   // Password reader with fixed waits
   csg_pw_reader u_reader
   (
      .clk_i (clk_i),
      .srst_i (srst_i),
      .rd_start_i (rd_start),
      .rd_idx_i (cpu_addr_i[2:0]),
      .fl_rdata_i (fl_rdata_i),
      .rd_done_o (rd_done),
      .rd_data_o (rd_data),
      .pw_bus (pw_bus.reader)
   );

   // Key against password compare
   csg_key_cmp u_cmp
   (
      .clk_i (clk_i),
      .srst_i (srst_i),
      .pw_bus (pw_bus.cmp)
   );

   // ****************************************
   // Bus decode
   // ****************************************
   csg_pkg::csg_bus_e bus_ff; // Front end state
   logic is_key; // Key word address
   logic is_pw; // Password word address
   logic take; // Request taken this cycle
   logic ack_ff; // Bus answer
   logic [15:0] rdata_ff; // Read data
   logic [21:0] fl_addr_ff; // Flash address

   assign take = cpu_req_i && (bus_ff == csg_pkg::CSG_BUS_IDLE);

   // Address decode
   always_comb
   begin
      is_key = 1'b0;
      is_pw = 1'b0;
      if (cpu_addr_i[21:3] == `CSG_KEY_BASE >> 3)
         is_key = 1'b1;
      else if (cpu_addr_i[21:3] == `CSG_PW_BASE >> 3)
         is_pw = 1'b1;
   end

   assign rd_start = take && !cpu_we_i && is_pw;

   // Front end sequencing
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         bus_ff <= csg_pkg::CSG_BUS_IDLE;
      else
      begin
         case (bus_ff)
            csg_pkg::CSG_BUS_IDLE:
            begin
               // Password reads wait, all else answers next cycle
               if (rd_start)
                  bus_ff <= csg_pkg::CSG_BUS_PW;
               else if (take)
                  bus_ff <= csg_pkg::CSG_BUS_ACK;
            end
            csg_pkg::CSG_BUS_PW:
            begin
               // Hold until the fixed waits end
               if (rd_done)
                  bus_ff <= csg_pkg::CSG_BUS_ACK;
            end
            default:
               bus_ff <= csg_pkg::CSG_BUS_IDLE;
         endcase
      end
   end

   // Answer strobe and read data
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         ack_ff <= 1'b0;
         rdata_ff <= 16'h0000;
      end
      else
      begin
         ack_ff <= (take && !rd_start) || ((bus_ff == csg_pkg::CSG_BUS_PW) && rd_done);
         // Key words and unmapped reads return zero
         if (take && !rd_start)
            rdata_ff <= 16'h0000;
         else if ((bus_ff == csg_pkg::CSG_BUS_PW) && rd_done)
            rdata_ff <= rd_data;
      end
   end

   // Flash address of the password word
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         fl_addr_ff <= 22'h000000;
      else if (rd_start)
         fl_addr_ff <= cpu_addr_i;
   end

   assign cpu_ack_o = ack_ff;
   assign cpu_rdata_o = rdata_ff;
   assign fl_addr_o = fl_addr_ff;

   // ****************************************
   // Key words
   // ****************************************
   for (genvar g = 0; g < `CSG_NUM_WORDS; g++)
   begin : g_key
      // Write one key word
      always_ff @(posedge clk_i)
      begin
         if (srst_i)
            key_ff[g] <= `CSG_KEY_RST;
         else if (take && cpu_we_i && is_key && (cpu_addr_i[2:0] == 3'(g)))
            key_ff[g] <= cpu_wdata_i;
      end
      assign pw_bus.key[16*g +: 16] = key_ff[g];
   end

   // ****************************************
   // Lock state
   // ****************************************
   logic unlock_ff; // Code guard open
   logic emu_ok_ff; // Emulation of secure code allowed
   logic all_seen; // Every password word read

   assign all_seen = &pw_bus.seen;

   // Lock flags follow compare and reads
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         unlock_ff <= 1'b0;
         emu_ok_ff <= 1'b0;
      end
      else
      begin
         unlock_ff <= all_seen && pw_bus.full_match;
         emu_ok_ff <= all_seen && (pw_bus.low_match || pw_bus.full_match);
      end
   end

   assign locked_o = !unlock_ff;
   assign emu_unlocked_o = emu_ok_ff;

   // ****************************************
   // Access check
   // ****************************************
   logic in_sec; // Address in secure memory

   always_comb
   begin
      if ((acc_addr_i >= `CSG_FLASH_LO) && (acc_addr_i <= `CSG_FLASH_HI))
         in_sec = 1'b1;
      else if ((acc_addr_i >= `CSG_OTP_LO) && (acc_addr_i <= `CSG_OTP_HI))
         in_sec = 1'b1;
      else if ((acc_addr_i >= `CSG_LRAM_LO) && (acc_addr_i <= `CSG_LRAM_HI))
         in_sec = 1'b1;
      else
         in_sec = 1'b0;
   end

   assign acc_secure_o = in_sec;

   assign acc_grant_o = acc_valid_i && (!in_sec || unlock_ff ||
                        (acc_src_i == csg_pkg::CSG_SRC_CPU));

   // ****************************************
   // Emulation guard
   // ****************************************
   logic [1:0] pin_s1_ff; // First synchroniser stage
   logic [1:0] pin_s2_ff; // Second synchroniser stage
   logic cut_ff; // Emulation link cut
   logic trip; // Guard trip condition

   // Two-stage sync of emulator pins
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         pin_s1_ff <= 2'h0;
         pin_s2_ff <= 2'h0;
      end
      else
      begin
         pin_s1_ff <= {emu_hold_req_i, emu_present_i};
         pin_s2_ff <= pin_s1_ff;
      end
   end

   assign trip = pin_s2_ff[0] && acc_valid_i && in_sec && !emu_ok_ff;

   // Sticky cut until reset
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         cut_ff <= 1'b0;
      else if (trip)
         cut_ff <= 1'b1;
   end

   assign emu_link_en_o = !cut_ff;
   assign cpu_hold_o = pin_s2_ff[1];

   // ****************************************
   // Checks
   // ****************************************
   chk_reset_locked: assert property (@(posedge clk_i)
      srst_i |=> locked_o && !emu_unlocked_o)
      else $error("guard not locked after reset");

   chk_locked_refuse: assert property (@(posedge clk_i) disable iff (srst_i)
      acc_valid_i && acc_secure_o && locked_o && (acc_src_i != csg_pkg::CSG_SRC_CPU)
      |-> !acc_grant_o)
      else $error("locked guard granted outside access");

   chk_unlock_cause: assert property (@(posedge clk_i) disable iff (srst_i)
      $rose(!locked_o) |-> $past(pw_bus.full_match))
      else $error("unlock without full key match");

   chk_reads_first: assert property (@(posedge clk_i) disable iff (srst_i)
      !locked_o || emu_unlocked_o |-> $past(&pw_bus.seen))
      else $error("unlock before all password reads");

   chk_emu_cut: assert property (@(posedge clk_i) disable iff (srst_i)
      trip |=> !emu_link_en_o [*3])
      else $error("secure access did not cut emulation");

   chk_emu_half: assert property (@(posedge clk_i) disable iff (srst_i)
      $rose(emu_unlocked_o) |-> $past(pw_bus.low_match || pw_bus.full_match))
      else $error("emulation opened without lower match");

   chk_flash_secure: assert property (@(posedge clk_i) disable iff (srst_i)
      (acc_addr_i[21:16] == 6'h30) |-> acc_secure_o)
      else $error("flash address not treated as secure");

   chk_pw_ack: assert property (@(posedge clk_i) disable iff (srst_i)
      rd_start |-> !cpu_ack_o [*8] ##11 cpu_ack_o)
      else $error("password read answer not after 18 cycles");

   chk_key_store: assert property (@(posedge clk_i) disable iff (srst_i)
      take && cpu_we_i && is_key |=>
      pw_bus.key[16*$past(cpu_addr_i[2:0]) +: 16] == $past(cpu_wdata_i))
      else $error("key write not stored");

   cov_unlock: cover property (@(posedge clk_i) disable iff (srst_i) $rose(!locked_o));
   cov_emu_only: cover property (@(posedge clk_i) disable iff (srst_i)
      emu_unlocked_o && locked_o);
   cov_trip: cover property (@(posedge clk_i) disable iff (srst_i) $rose(cut_ff));

endmodule // csg_gate

// ### bench/csg_flash_model.sv
`timescale 1ns/1ps

// ****************************************
// Flash model holding the password words
// ****************************************
module csg_flash_model
(
   // Password contents
   input wire logic [127:0] pw_i,
   // Flash read port
   input wire logic [21:0] fl_addr_i,
   output logic [15:0] fl_rdata_o
);
   // Word lookup, steady while the address stands
   always_comb
   begin
      if (fl_addr_i >= 22'h33FFF8 && fl_addr_i <= 22'h33FFFF)
      begin
         // Password word, word 0 holds bits 15:0
         fl_rdata_o = pw_i[16 * fl_addr_i[2:0] +: 16];
      end
      else if (fl_addr_i >= 22'h33FF80 && fl_addr_i <= 22'h33FFF5)
      begin
         fl_rdata_o = 16'h0000;
      end
      else
      begin
         // Other cells follow the address, never a stale value
         fl_rdata_o = ~fl_addr_i[15:0];
      end
   end
endmodule // csg_flash_model

// ### bench/test_code_security_gate.sv
`timescale 1ns/1ps
`include "csg_defs.svh"

module test_code_security_gate;
   // ****************************************
   // Stimulus and wiring
   // ****************************************
   // Password sets
   localparam logic [127:0] PW_SET = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
   localparam logic [127:0] PW_BLANK = 128'h1357_9BDF_2468_ACE0_FFFF_FFFF_FFFF_FFFF;
   // Probe addresses, the first six are secure
   localparam logic [21:0] ADR [8] = '{22'h300000, 22'h33FFFF, 22'h380400, 22'h3807FF,
      22'h008000, 22'h00BFFF, 22'h007FFF, 22'h340000};
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic cpu_req_i = 1'b0;
   logic cpu_we_i = 1'b0;
   logic [21:0] cpu_addr_i = 22'h000000;
   logic [15:0] cpu_wdata_i = 16'h0000;
   logic cpu_ack_o;
   logic [15:0] cpu_rdata_o;
   logic [21:0] fl_addr_o;
   logic [15:0] fl_rdata_i;
   logic acc_valid_i = 1'b0;
   logic [21:0] acc_addr_i = 22'h000000;
   csg_pkg::csg_src_e acc_src_i = csg_pkg::CSG_SRC_CPU;
   logic acc_secure_o;
   logic acc_grant_o;
   logic emu_present_i = 1'b0;
   logic emu_hold_req_i = 1'b0;
   logic emu_link_en_o;
   logic cpu_hold_o;
   logic locked_o;
   logic emu_unlocked_o;
   logic [127:0] pw_val = PW_SET;
   int errors = 0;
   int total_checks = 0;

   // Free-running clock
   always #20 clk_i = ~clk_i;

   csg_gate uut (.clk_i(clk_i), .srst_i(srst_i), .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i),
      .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i), .cpu_ack_o(cpu_ack_o),
      .cpu_rdata_o(cpu_rdata_o), .fl_addr_o(fl_addr_o), .fl_rdata_i(fl_rdata_i),
      .acc_valid_i(acc_valid_i), .acc_addr_i(acc_addr_i), .acc_src_i(acc_src_i),
      .acc_secure_o(acc_secure_o), .acc_grant_o(acc_grant_o),
      .emu_present_i(emu_present_i), .emu_hold_req_i(emu_hold_req_i),
      .emu_link_en_o(emu_link_en_o), .cpu_hold_o(cpu_hold_o), .locked_o(locked_o),
      .emu_unlocked_o(emu_unlocked_o));

   csg_flash_model model (.pw_i(pw_val), .fl_addr_i(fl_addr_o), .fl_rdata_o(fl_rdata_i));

   // ****************************************
   // Shared tasks
   // ****************************************
   // Compare and count
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // Closing verdict
   task automatic results;
      $display("Checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Wait edges, then step just past the last one
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // Reset with a new password in flash
   task automatic do_reset(input logic [127:0] pw);
      pw_val = pw;
      srst_i = 1'b1;
      tick(8);
      srst_i = 1'b0;
   endtask

   // One bus transfer, request held until the answer
   task automatic bus(input logic we, input logic [21:0] a, input logic [15:0] wd,
                      output logic [15:0] rd, output int lat);
      cpu_req_i = 1'b1;
      cpu_we_i = we;
      cpu_addr_i = a;
      cpu_wdata_i = wd;
      lat = 0;
      do
      begin
         tick(1);
         lat++;
      end
      while (cpu_ack_o !== 1'b1 && lat < 40);
      // A missing answer counts as a mismatch
      if (cpu_ack_o !== 1'b1)
         errors++;
      rd = cpu_rdata_o;
      cpu_req_i = 1'b0;
      // Let the front end return to idle before the next request
      tick(1);
   endtask

   // Optional password reads, then the key words
   task automatic unlock(input logic [127:0] pw, input logic [127:0] key, input logic reads);
      logic [15:0] rd;
      int lat;
      for (int i = 0; i < 8 && reads; i++)
      begin
         bus(1'b0, `CSG_PW_BASE + 22'(i), 16'h0000, rd, lat);
         check(lat, 18);
         check(rd, pw[16 * i +: 16]);
      end
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b1, `CSG_KEY_BASE + 22'(i), key[16 * i +: 16], rd, lat);
         check(lat, 1);
      end
      tick(3);
   endtask

   // Combinational access check
   task automatic probe(input logic [21:0] a, input int s, input logic sec, input logic gr);
      acc_valid_i = 1'b1;
      acc_addr_i = a;
      acc_src_i = csg_pkg::csg_src_e'(s);
      #1;
      check(acc_secure_o, sec);
      check(acc_grant_o, gr);
      acc_valid_i = 1'b0;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   // Reset state
   task automatic t_reset;
      do_reset(PW_SET);
      check({locked_o, emu_unlocked_o, emu_link_en_o, cpu_hold_o}, 4'hA);
      $display("test reset done");
   endtask

   // Every region against every source while locked
   task automatic t_access;
      for (int i = 0; i < 8; i++)
         for (int s = 0; s < 4; s++)
            probe(ADR[i], s, i < 6, i >= 6 || s == 0);
      #1;
      check(acc_grant_o, 1'b0);
      $display("test access done");
   endtask

   // Correct key without the dummy reads
   task automatic t_noreads;
      logic [15:0] rd;
      int lat;
      do_reset(PW_SET);
      unlock(PW_SET, PW_SET, 1'b0);
      check({locked_o, emu_unlocked_o}, 2'b10);
      bus(1'b0, `CSG_KEY_BASE, 16'h0000, rd, lat);
      check(rd, 16'h0000);
      $display("test no reads done");
   endtask

   // Full unlock, then the upper half spoilt
   task automatic t_full;
      logic [15:0] rd;
      int lat;
      do_reset(PW_SET);
      unlock(PW_SET, PW_SET, 1'b1);
      check({locked_o, emu_unlocked_o}, 2'b01);
      probe(ADR[0], 1, 1'b1, 1'b1);
      bus(1'b1, `CSG_KEY_BASE + 22'h7, ~PW_SET[127:112], rd, lat);
      tick(3);
      check({locked_o, emu_unlocked_o}, 2'b11);
      probe(ADR[4], 1, 1'b1, 1'b0);
      $display("test full unlock done");
   endtask

   // Blank lower password and all-zero password
   task automatic t_blank;
      do_reset(PW_BLANK);
      unlock(PW_BLANK, 128'h0, 1'b1);
      check({locked_o, emu_unlocked_o}, 2'b11);
      do_reset(128'h0);
      unlock(128'h0, 128'h0, 1'b1);
      check({locked_o, emu_unlocked_o}, 2'b10);
      $display("test blank done");
   endtask

   // Emulator trip, no trip when unlocked, hold in reset
   task automatic t_emu;
      do_reset(PW_SET);
      emu_present_i = 1'b1;
      acc_addr_i = ADR[6];
      acc_valid_i = 1'b1;
      tick(4);
      check(emu_link_en_o, 1'b1);
      acc_addr_i = ADR[2];
      tick(2);
      acc_valid_i = 1'b0;
      tick(5);
      check(emu_link_en_o, 1'b0);
      emu_present_i = 1'b0;
      do_reset(PW_SET);
      unlock(PW_SET, PW_SET, 1'b1);
      emu_present_i = 1'b1;
      acc_addr_i = ADR[0];
      acc_valid_i = 1'b1;
      tick(5);
      check(emu_link_en_o, 1'b1);
      acc_valid_i = 1'b0;
      emu_hold_req_i = 1'b1;
      tick(4);
      check(cpu_hold_o, 1'b1);
      emu_hold_req_i = 1'b0;
      tick(4);
      check(cpu_hold_o, 1'b0);
      $display("test emulator done");
   endtask

   // Main sequence
   initial
   begin
      tick(1);
      t_reset;
      t_access;
      t_noreads;
      t_full;
      t_blank;
      t_emu;
      results;
   end

   // Watchdog against a hang
   initial
   begin
      #(40 * 20000);
      errors++;
      results;
   end
endmodule // test_code_security_gate
